// ### hdl/asm_pkg.sv
// Package of register map constants for the ADC status and mode registers
package asm_pkg;
  // ==========================================================================
  // Register select codes
  localparam logic [2:0]  RS_STATUS         = 3'h0;
  localparam logic [2:0]  RS_MODE           = 3'h1;
  // ==========================================================================
  // Reset values
  localparam logic [7:0]  STATUS_RESET      = 8'h80;
  localparam logic [15:0] MODE_RESET        = 16'h000a;
  // ==========================================================================
  // Field positions
  localparam int          SR_READY_BIT      = 7;
  localparam int          SR_ERROR_BIT      = 6;
  localparam int          MR_MODE_LSB       = 13;
  localparam int          MR_CLK_LSB        = 6;
  localparam int          MR_RATE_LSB       = 0;
  localparam int          CMD_RW_BIT        = 6;
  localparam int          CMD_RS_LSB        = 3;
  // ==========================================================================
  // Mode and clock codes
  localparam logic [2:0]  MODE_CONTINUOUS   = 3'h0;
  localparam logic [2:0]  MODE_POWER_DOWN   = 3'h3;
  localparam logic [1:0]  CLK_INT           = 2'h0;
  localparam logic [1:0]  CLK_INT_OUT       = 2'h1;
  localparam logic [1:0]  CLK_EXT           = 2'h2;
  localparam logic [1:0]  CLK_EXT_DIV2      = 2'h3;
  // ==========================================================================
  // Timing: internal converter clock 64 kHz derived from 40 MHz system clock
  localparam int          SYS_CLOCK_HZ      = 40000000;
  localparam int          INT_CLOCK_HZ      = 64000;
  localparam int          INT_HALF_CYCLES   = SYS_CLOCK_HZ / (2 * INT_CLOCK_HZ);
  // Serial states, Gray coded along command, data path
  typedef enum logic [1:0] {
    ASM_IDLE  = 2'b00,
    ASM_CMD   = 2'b01,
    ASM_SHIFT = 2'b11
  } asm_state_e;
endpackage : asm_pkg

// ### hdl/asm_clock_select.sv
// Converter clock source selection and clock pin control
`timescale 1ns/1ps
`default_nettype none
module asm_clock_select
  import asm_pkg::*;
#(
  parameter int HALF_CYCLES = INT_HALF_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic [1:0] clock_source_select,
  input  wire logic       clk_pin_in,
  output logic            clk_pin_out,
  output logic            clk_pin_oe_n,
  output logic            conv_tick
);
  logic [15:0] div_reg,  div_next;
  logic        int_reg,  int_next;
  logic        ext_reg,  ext_next;
  logic        half_reg, half_next;
  logic        tick_next;
  logic        pin_out_next, oe_n_next;

  // Internal oscillator, external edge detect, divide by two
  always_comb begin
    div_next  = div_reg;
    int_next  = int_reg;
    half_next = half_reg;
    ext_next  = clk_pin_in;
    tick_next = 1'b0;
    if (div_reg == 16'(HALF_CYCLES - 1)) begin
      div_next = 16'h0000;
      int_next = ~int_reg;
    end else begin
      div_next = div_reg + 16'h0001;
    end
    case (clock_source_select)
      CLK_INT, CLK_INT_OUT: tick_next = (div_reg == 16'(HALF_CYCLES - 1))
                                        && !int_reg;
      CLK_EXT: tick_next = clk_pin_in && !ext_reg;
      CLK_EXT_DIV2: begin
        if (clk_pin_in && !ext_reg) begin
          half_next = ~half_reg;
          tick_next = half_reg;
        end
      end
      default: tick_next = 1'b0;
    endcase
    // Pin only driven when internal clock is offered outward
    oe_n_next    = (clock_source_select != CLK_INT_OUT);
    pin_out_next = int_next & (clock_source_select == CLK_INT_OUT);
  end

  // Registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_reg      <= 16'h0000;
      int_reg      <= 1'b0;
      ext_reg      <= 1'b0;
      half_reg     <= 1'b0;
      conv_tick    <= 1'b0;
      clk_pin_out  <= 1'b0;
      clk_pin_oe_n <= 1'b1;
    end else if (clk_en) begin
      div_reg      <= div_next;
      int_reg      <= int_next;
      ext_reg      <= ext_next;
      half_reg     <= half_next;
      conv_tick    <= tick_next;
      clk_pin_out  <= pin_out_next;
      clk_pin_oe_n <= oe_n_next;
    end
  end
endmodule : asm_clock_select
`default_nettype wire

// ### hdl/asm_status_mode_regs.sv
// Status and mode registers behind the three-wire serial port
// Overview of operation
// - 8-bit read-only status, resets to 0x80
// - Status shifted out most significant bit first
// - Ready clears on new result, sets on read
// - Ready sets on entering power-down mode
// - Error updates with ready, marks clamped result
// - Error clears on conversion-starting register write
// - Status bits 5 to 3 read zero
// - Status bits 2 to 0 give channel index
// - 16-bit read/write mode register, select 001
// - Mode register moves most significant bit first
// - Mode write resets modulator, filter; sets ready
// - Mode bits 15 to 13 select operating mode
// - Clock code 00 internal, pin not driven
// - Clock code 01 internal, driven on pin
// - Clock code 10 external clock used directly
// - Clock code 11 external clock halved
// - Mode bits 3 to 0 rate, reset 1010
// - Mode 000 converts continuously into data register
`timescale 1ns/1ps
`default_nettype none
module asm_status_mode_regs
  import asm_pkg::*;
#(
  parameter int HALF_CYCLES = INT_HALF_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic       serial_clk,
  input  wire logic       serial_cs_n,
  input  wire logic       serial_din,
  output logic            serial_dout,
  input  wire logic       result_valid,
  input  wire logic       result_clamped,
  input  wire logic [2:0] converting_channel_index,
  input  wire logic       data_reg_read,
  input  wire logic       clk_pin_in,
  output logic            clk_pin_out,
  output logic            clk_pin_oe_n,
  output logic            conv_tick,
  output logic            filter_reset,
  output logic [2:0]      operating_mode_select,
  output logic [3:0]      update_rate_select,
  output logic            continuous_convert,
  output logic            ready_n
);
  // ==========================================================================
  // Serial command and shift engine
  asm_state_e  state_reg, state_next;
  logic [2:0]  cnt_reg,   cnt_next;
  logic [3:0]  bit_reg,   bit_next;
  logic [15:0] sh_reg,    sh_next;
  logic        rd_reg,    rd_next;
  logic [2:0]  sel_reg,   sel_next;
  logic        sclk_reg,  sclk_next;
  logic        dout_next;
  logic        mode_wr;
  logic [15:0] mode_reg,  mode_next;
  logic        rdy_reg,   rdy_next;
  logic        err_reg,   err_next;
  logic        frst_next, cont_next;
  logic [2:0]  chan_reg,  chan_next;
  logic [7:0]  status_view;
  logic        rise;

  assign rise = serial_clk && !sclk_reg && !serial_cs_n;
  assign status_view = {rdy_reg, err_reg, 3'h0, chan_reg};

  // Bits sampled on rising serial clock; data in idle waits for a zero gate
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    bit_next   = bit_reg;
    sh_next    = sh_reg;
    rd_next    = rd_reg;
    sel_next   = sel_reg;
    sclk_next  = serial_clk;
    dout_next  = serial_dout;
    mode_wr    = 1'b0;
    if (serial_cs_n) begin
      state_next = ASM_IDLE;
    end else if (rise) begin
      case (state_reg)
        ASM_IDLE: begin
          if (!serial_din) begin
            state_next = ASM_CMD;
            cnt_next   = 3'h0;
          end
        end
        ASM_CMD: begin
          sh_next  = {sh_reg[14:0], serial_din};
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == 3'h6) begin
            rd_next  = sh_reg[5];
            sel_next = sh_reg[4:2];
            if (sh_reg[4:2] == RS_MODE) begin
              state_next = ASM_SHIFT;
              bit_next   = 4'hf;
              sh_next    = mode_reg;
              dout_next  = sh_reg[5] ? mode_reg[15] : 1'b1;
            end else if (sh_reg[4:2] == RS_STATUS && sh_reg[5]) begin
              state_next = ASM_SHIFT;
              bit_next   = 4'h7;
              sh_next    = {status_view, 8'h00};
              dout_next  = status_view[7];
            end else begin
              state_next = ASM_IDLE;
            end
          end
        end
        ASM_SHIFT: begin
          // Shift left so the top bit always leaves first
          sh_next  = {sh_reg[14:0], serial_din};
          bit_next = bit_reg - 4'h1;
          if (rd_reg) begin
            dout_next = sh_reg[14];
          end
          if (bit_reg == 4'h0) begin
            state_next = ASM_IDLE;
            dout_next  = 1'b1;
            mode_wr    = !rd_reg && (sel_reg == RS_MODE);
          end
        end
        default: state_next = ASM_IDLE;
      endcase
    end
  end

  // Mode register and status flags
  always_comb begin
    mode_next = mode_reg;
    rdy_next  = rdy_reg;
    err_next  = err_reg;
    chan_next = converting_channel_index;
    frst_next = 1'b0;
    if (mode_wr) begin
      // Whole word stored, reserved bits included, for readback
      mode_next = {sh_reg[14:0], serial_din};
    end
    // Ready back high after read or mode write; new result wins over read, mode write and power-down win over result
    if (data_reg_read) begin
      rdy_next = 1'b1;
    end
    if (mode_wr) begin
      frst_next = 1'b1;
      rdy_next  = 1'b1;
      err_next  = 1'b0;
    end
    if (mode_next[15:13] == MODE_POWER_DOWN) begin
      rdy_next = 1'b1;
    end else if (result_valid && !mode_wr) begin
      rdy_next = 1'b0;
      err_next = result_clamped;
    end
    cont_next = (mode_next[15:13] == MODE_CONTINUOUS);
  end

  // Registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg             <= ASM_IDLE;
      cnt_reg               <= 3'h0;
      bit_reg               <= 4'h0;
      sh_reg                <= 16'h0000;
      rd_reg                <= 1'b0;
      sel_reg               <= 3'h0;
      sclk_reg              <= 1'b1;
      serial_dout           <= 1'b1;
      mode_reg              <= MODE_RESET;
      rdy_reg               <= STATUS_RESET[SR_READY_BIT];
      err_reg               <= STATUS_RESET[SR_ERROR_BIT];
      chan_reg              <= 3'h0;
      filter_reset          <= 1'b0;
      continuous_convert    <= 1'b1;
      operating_mode_select <= MODE_RESET[15:13];
      update_rate_select    <= MODE_RESET[3:0];
      ready_n               <= STATUS_RESET[SR_READY_BIT];
    end else if (clk_en) begin
      state_reg             <= state_next;
      cnt_reg               <= cnt_next;
      bit_reg               <= bit_next;
      sh_reg                <= sh_next;
      rd_reg                <= rd_next;
      sel_reg               <= sel_next;
      sclk_reg              <= sclk_next;
      serial_dout           <= dout_next;
      mode_reg              <= mode_next;
      rdy_reg               <= rdy_next;
      err_reg               <= err_next;
      chan_reg              <= chan_next;
      filter_reset          <= frst_next;
      continuous_convert    <= cont_next;
      operating_mode_select <= mode_next[15:13];
      update_rate_select    <= mode_next[3:0];
      ready_n               <= rdy_next;
    end
  end

  // ==========================================================================
  // Converter clock source
  asm_clock_select #(
    .HALF_CYCLES (HALF_CYCLES)
  ) u_clk (
    .clock               (clock),
    .arst_n              (arst_n),
    .clk_en              (clk_en),
    .clock_source_select (mode_reg[7:6]),
    .clk_pin_in          (clk_pin_in),
    .clk_pin_out         (clk_pin_out),
    .clk_pin_oe_n        (clk_pin_oe_n),
    .conv_tick           (conv_tick)
  );

  // ==========================================================================
  // Checks
  sequence s_mode_write;
    mode_wr && clk_en;
  endsequence

  property p_reset_status;
    @(posedge clock) $rose(arst_n) |-> status_view == STATUS_RESET;
  endproperty
  a_reset_status: assert property (p_reset_status) else $error("status reset");

  property p_mode_sets_ready;
    @(posedge clock) disable iff (!arst_n)
      s_mode_write |=> rdy_reg && !err_reg && filter_reset;
  endproperty
  a_mode_sets_ready: assert property (p_mode_sets_ready) else $error("mode write");

  property p_result_clears_ready;
    @(posedge clock) disable iff (!arst_n)
      clk_en && result_valid && !mode_wr && mode_next[15:13] != MODE_POWER_DOWN
      |=> !rdy_reg && err_reg == $past(result_clamped);
  endproperty
  a_result_clears_ready: assert property (p_result_clears_ready) else $error("result");

  property p_power_down_ready;
    @(posedge clock) disable iff (!arst_n)
      mode_reg[15:13] == MODE_POWER_DOWN |-> rdy_reg;
  endproperty
  a_power_down_ready: assert property (p_power_down_ready) else $error("pd ready");

  // Bits 5 to 3 checked on the pin, not on the internal view
  property p_zero_bits;
    @(posedge clock) disable iff (!arst_n)
      state_reg == ASM_SHIFT && sel_reg == RS_STATUS
      && bit_reg inside {4'h5, 4'h4, 4'h3} |-> !serial_dout;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("zero bits");

  property p_mode_store;
    @(posedge clock) disable iff (!arst_n)
      s_mode_write |=> mode_reg == $past({sh_reg[14:0], serial_din});
  endproperty
  a_mode_store: assert property (p_mode_store) else $error("mode store");

  // Pin enable lags the clock source code by one register stage
  property p_pin_drive;
    @(posedge clock) disable iff (!arst_n)
      clk_en |=> clk_pin_oe_n == ($past(mode_reg[7:6]) != CLK_INT_OUT);
  endproperty
  a_pin_drive: assert property (p_pin_drive)
    else $error("clock pin");

  property p_rate_out;
    @(posedge clock) disable iff (!arst_n)
      update_rate_select == mode_reg[3:0] && continuous_convert == (mode_reg[15:13] == 3'h0);
  endproperty
  a_rate_out: assert property (p_rate_out) else $error("rate out");

  // Command byte complete: first data bit must already stand on the pin
  sequence s_cmd_done;
    clk_en && arst_n && state_reg == ASM_CMD && rise && cnt_reg == 3'h6;
  endsequence

  property p_status_first;
    @(posedge clock) disable iff (!arst_n)
      s_cmd_done ##0 (sh_reg[5] && sh_reg[4:2] == RS_STATUS)
      |=> serial_dout == $past(rdy_reg);
  endproperty
  a_status_first: assert property (p_status_first)
    else $error("status msb");

  property p_mode_first;
    @(posedge clock) disable iff (!arst_n)
      s_cmd_done ##0 (sh_reg[5] && sh_reg[4:2] == RS_MODE)
      |=> serial_dout == $past(mode_reg[15]);
  endproperty
  a_mode_first: assert property (p_mode_first)
    else $error("mode msb");

  // A one in idle must not open a command
  property p_gate;
    @(posedge clock) disable iff (!arst_n)
      clk_en && state_reg == ASM_IDLE && rise && serial_din
      |=> state_reg == ASM_IDLE;
  endproperty
  a_gate: assert property (p_gate)
    else $error("write gate");

  // Gated by reset so the edge after release is not judged
  property p_chan;
    @(posedge clock) disable iff (!arst_n)
      clk_en && arst_n
      |=> status_view[2:0] == $past(converting_channel_index);
  endproperty
  a_chan: assert property (p_chan)
    else $error("channel index");

  property p_read_sets_ready;
    @(posedge clock) disable iff (!arst_n)
      clk_en && arst_n && data_reg_read && !result_valid |=> rdy_reg;
  endproperty
  a_read_sets_ready: assert property (p_read_sets_ready)
    else $error("read ready");
endmodule : asm_status_mode_regs
`default_nettype wire

// ### testbench/asm_host_model.sv
// Host model driving the three-wire serial port of the register bank
`timescale 1ns/1ps
`default_nettype none
module asm_host_model (
  input  wire logic clock,
  input  wire logic serial_dout,
  output var logic  serial_clk,
  output var logic  serial_cs_n,
  output var logic  serial_din
);
  // ==========================================================================
  // Idle levels: serial clock stands low outside frames
  initial begin
    serial_clk  = 1'b0;
    serial_cs_n = 1'b1;
    serial_din  = 1'b0;
  end

  // One bit: two clocks low then high, sampled before the rise
  task automatic bit_out(input logic b, output logic got);
    @(posedge clock);
    serial_clk <= 1'b0;
    serial_din <= b;
    repeat (2) @(posedge clock);
    got = serial_dout;
    serial_clk <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : bit_out

  // Whole frame: leading ones, command byte, then n data bits
  task automatic frame(input int pre, input logic [7:0] cmd, input int n,
                       input logic [15:0] wdata, output logic [15:0] rdata);
    logic got;
    rdata = 16'h0000;
    @(posedge clock);
    serial_cs_n <= 1'b0;
    for (int i = 0; i < pre; i++) bit_out(1'b1, got);
    for (int i = 7; i >= 0; i--) bit_out(cmd[i], got);
    for (int i = n - 1; i >= 0; i--) begin
      bit_out(wdata[i], got);
      rdata = {rdata[14:0], got};
    end
    @(posedge clock);
    serial_clk  <= 1'b0;
    serial_cs_n <= 1'b1;
    serial_din  <= ~serial_din; // Released line must not echo old data
    repeat (3) @(posedge clock);
  endtask : frame
endmodule : asm_host_model
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the status and mode register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import asm_pkg::*;
  localparam int HC = 4;
  logic       clock, arst_n, clk_en, result_valid, result_clamped;
  logic       data_reg_read, serial_clk, serial_cs_n, serial_din;
  logic       serial_dout, clk_pin_out, clk_pin_oe_n, conv_tick;
  logic       filter_reset, continuous_convert, ready_n;
  logic [2:0] converting_channel_index, operating_mode_select;
  logic [3:0] update_rate_select, ext_div;
  wire        clk_pin_in = clk_pin_oe_n ? ext_div[3] : clk_pin_out;
  int         miscompares, tests_run, tick_cnt, fr_cnt;

  asm_status_mode_regs #(.HALF_CYCLES(HC)) u_asm_status_mode_regs (
    .clock(clock), .arst_n(arst_n), .clk_en(clk_en),
    .serial_clk(serial_clk), .serial_cs_n(serial_cs_n),
    .serial_din(serial_din), .serial_dout(serial_dout),
    .result_valid(result_valid), .result_clamped(result_clamped),
    .converting_channel_index(converting_channel_index),
    .data_reg_read(data_reg_read), .clk_pin_in(clk_pin_in),
    .clk_pin_out(clk_pin_out), .clk_pin_oe_n(clk_pin_oe_n),
    .conv_tick(conv_tick), .filter_reset(filter_reset),
    .operating_mode_select(operating_mode_select),
    .update_rate_select(update_rate_select),
    .continuous_convert(continuous_convert), .ready_n(ready_n));

  asm_host_model u_asm_host_model (
    .clock(clock), .serial_dout(serial_dout), .serial_clk(serial_clk),
    .serial_cs_n(serial_cs_n), .serial_din(serial_din));

  // ==========================================================================
  // Clock, external pin clock at 16 system clocks, event counters
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    ext_div <= ext_div + 4'h1;
    if (conv_tick === 1'b1) tick_cnt++;
    if (filter_reset === 1'b1) fr_cnt++;
  end

  // ==========================================================================
  // Expectations and comparisons
  function automatic logic [15:0] exp_status(logic r, logic e, logic [2:0] c);
    return {8'h00, r, e, 3'b000, c};
  endfunction : exp_status
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit
  // Counts sampled against a free-running clock may slip by one
  task automatic cmp_cnt(input int got, input int exp);
    tests_run++;
    if (got < exp - 1 || got > exp + 1) begin
      miscompares++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : cmp_cnt
  task automatic close_out();
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  // ==========================================================================
  // Main sequence
  initial begin
    logic [15:0] r, w;
    logic [2:0]  ch;
    logic        c;
    int          f0, t0;
    arst_n = 1'b0;
    clk_en = 1'b1;
    result_valid = 1'b0;
    result_clamped = 1'b0;
    data_reg_read = 1'b0;
    converting_channel_index = 3'h0;
    ext_div = 4'h0;
    void'($urandom(98));
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    u_asm_host_model.frame(0, {2'b01, RS_STATUS, 3'h0}, 8, 16'h0, r);
    cmp_val(r, exp_status(1'b1, 1'b0, 3'h0));
    u_asm_host_model.frame(0, {2'b01, RS_MODE, 3'h0}, 16, 16'h0, r);
    cmp_val(r, MODE_RESET);
    cmp_bit(continuous_convert, 1'b1);
    // Result, status read, then a mode write of every mode code
    for (int i = 0; i < 8; i++) begin
      ch = 3'($urandom);
      c = 1'($urandom);
      @(posedge clock);
      converting_channel_index <= ch;
      result_valid <= 1'b1;
      result_clamped <= c;
      @(posedge clock);
      result_valid <= 1'b0;
      result_clamped <= 1'b0;
      repeat (2) @(posedge clock);
      u_asm_host_model.frame(i % 3, {2'b01, RS_STATUS, 3'h0}, 8, 16'h0, r);
      cmp_val(r, exp_status(1'b0, c, ch));
      w = {3'(i + 4), 5'h00, 2'($urandom), 2'b00, 4'($urandom)};
      f0 = fr_cnt;
      u_asm_host_model.frame(0, {2'b00, RS_MODE, 3'h0}, 16, w, r);
      cmp_val(16'(fr_cnt - f0), 16'h0001);
      cmp_bit(ready_n, 1'b1);
      u_asm_host_model.frame(0, {2'b01, RS_STATUS, 3'h0}, 8, 16'h0, r);
      cmp_val(r, exp_status(1'b1, 1'b0, ch));
      u_asm_host_model.frame(0, {2'b01, RS_MODE, 3'h0}, 16, 16'h0, r);
      cmp_val(r, w);
      cmp_val({9'h0, operating_mode_select, update_rate_select},
              {9'h0, w[15:13], w[3:0]});
      cmp_bit(continuous_convert, w[15:13] == 3'h0);
    end
    // Reserved bits kept as written; unsupported command changes nothing
    u_asm_host_model.frame(0, {2'b00, RS_MODE, 3'h0}, 16, 16'h1f3a, r);
    f0 = fr_cnt;
    u_asm_host_model.frame(0, {2'b00, 3'h2, 3'h0}, 16, 16'hffff, r);
    u_asm_host_model.frame(0, {2'b01, RS_MODE, 3'h0}, 16, 16'h0, r);
    cmp_val(r, 16'h1f3a);
    cmp_val(16'(fr_cnt - f0), 16'h0000);
    // Data register read sets ready again
    @(posedge clock);
    result_valid <= 1'b1;
    @(posedge clock);
    result_valid <= 1'b0;
    repeat (2) @(posedge clock);
    cmp_bit(ready_n, 1'b0);
    data_reg_read <= 1'b1;
    @(posedge clock);
    data_reg_read <= 1'b0;
    repeat (2) @(posedge clock);
    cmp_bit(ready_n, 1'b1);
    // Frozen clock enable: a result pulse must leave ready untouched
    @(posedge clock);
    clk_en <= 1'b0;
    result_valid <= 1'b1;
    @(posedge clock);
    result_valid <= 1'b0;
    repeat (2) @(posedge clock);
    clk_en <= 1'b1;
    repeat (2) @(posedge clock);
    cmp_bit(ready_n, 1'b1);
    // Each clock source: pin drive and tick rate over 160 clocks
    for (int k = 0; k < 4; k++) begin
      w = {3'h0, 5'h00, 2'(k), 2'b00, 4'ha};
      u_asm_host_model.frame(0, {2'b00, RS_MODE, 3'h0}, 16, w, r);
      repeat (20) @(posedge clock);
      cmp_bit(clk_pin_oe_n, k != 1);
      t0 = tick_cnt;
      repeat (160) @(posedge clock);
      cmp_cnt(tick_cnt - t0, k < 2 ? 160 / (2 * HC) : (k == 2 ? 10 : 5));
    end
    // Mid-run reset after a clamped result: flags and mode back to reset
    @(posedge clock);
    result_valid <= 1'b1;
    result_clamped <= 1'b1;
    @(posedge clock);
    result_valid <= 1'b0;
    result_clamped <= 1'b0;
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    cmp_bit(ready_n, 1'b1);
    u_asm_host_model.frame(0, {2'b01, RS_STATUS, 3'h0}, 8, 16'h0, r);
    cmp_val(r, exp_status(1'b1, 1'b0, ch));
    u_asm_host_model.frame(0, {2'b01, RS_MODE, 3'h0}, 16, 16'h0, r);
    cmp_val(r, MODE_RESET);
    close_out();
  end

  // Hang guard, far beyond the few thousand cycles the run needs
  initial begin
    #1000000;
    miscompares++;
    close_out();
  end
endmodule : tb
`default_nettype wire
